// >>> logic/ocdbg_port.sv
// On-chip debugger serial port: single-wire link, autobaud, unlock, status over APB.
// Assumes pins synchronous to pclk and reset-source events as one-cycle pulses.
//
// Overview of operation
// [RULE1] Debug mode ends when software writes the control bit to zero or on any power-on, brown-out, watchdog or pin reset.
// [RULE2] A low debug line during stop mode requests a system reset and leaves debug mode.
// [RULE3] Each character is one low start bit, eight data bits least significant first, and one high stop bit.
// [RULE4] A reply may start as soon as the stop bit of the incoming character has been sampled.
// [RULE5] The host drives a stop bit high for at most half a bit time.
// [RULE6] The host should drive the debug line open-drain.
// [RULE7] After any reset the port sends nothing until the host has sent data.
// [RULE8] The host sends 80h as its first character after reset.
// [RULE9] The first character is measured as one unbroken low stretch of eight bit times.
// [RULE10] The low stretch is counted in clocks and divided by eight to give the bit period for receive and transmit.
// [RULE11] On small parts the port unlocks only after a 32-bit key on the debug line while the reset pin is low.
// [RULE12] After the reset pin rises on an unlocked part the line accepts the autobaud character and debug mode begins.
// [RULE13] Status bit 7 shows debug mode; all status bits are read-only and reset to zero. Bits 6 and 5 follow their inputs even in reset.
// [RULE14] Status bit 6 shows that the processor is halted.
// [RULE15] Status bit 5 is zero when the read-lock option is in force and one when it has no effect.
// [RULE16] Status bits 4 to 0 read as zero.
`timescale 1ns/1ps
module ocdbg_port
   import ocdbg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic debug_line_in,
   output logic debug_line_out,
   output logic debug_line_oe_n,
   input wire logic shared_reset_pin_in,
   input wire logic small_pin_part,
   input wire logic power_on_reset,
   input wire logic brown_out_reset,
   input wire logic watchdog_reset,
   input wire logic stop_mode,
   input wire logic cpu_halted,
   input wire logic flash_read_lock_option,
   output logic system_reset_req,
   output logic debug_mode
);

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == REG_STATE_REPORT) || (a == REG_CONTROL) || (a == REG_RX_DATA) ||
                  (a == REG_TX_DATA) || (a == REG_BIT_PERIOD);
   endfunction : is_mapped

   function automatic logic [CNT_W-1:0] at_least_one(input logic [CNT_W-1:0] v);
      at_least_one = (v < MIN_PERIOD) ? MIN_PERIOD : v;
   endfunction : at_least_one

   ocdbg_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [CNT_W-1:0] period, next_period;
   logic [3:0] bit_idx, next_bit_idx;
   logic [FRAME_BITS-1:0] shreg, next_shreg;
   logic [CNT_W-1:0] key_len, next_key_len;
   logic [KEY_BITS-1:0] key_shift, next_key_shift;
   logic [5:0] key_cnt, next_key_cnt;
   logic unlocked, next_unlocked;
   logic next_debug_mode;
   logic line_q;
   logic rx_hold_valid, next_rx_hold_valid;
   logic [7:0] rx_hold, next_rx_hold;
   logic tx_pend_valid, next_tx_pend_valid;
   logic [7:0] tx_pend, next_tx_pend;
   logic next_line_out, next_line_oe_n, next_sysrst;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;

   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0] fifo_out_data;

   logic hard_rst, pin_rst, stop_wake, apb_done, ctrl_write, tx_write;
   logic [CNT_W-1:0] target;
   ocdbg_status_t status;

   assign hard_rst = power_on_reset || brown_out_reset || watchdog_reset;
   assign pin_rst = !shared_reset_pin_in;
   assign stop_wake = stop_mode && !debug_line_in;
   assign apb_done = psel && penable && pready;
   assign ctrl_write = apb_done && pwrite && (paddr == REG_CONTROL);
   assign tx_write = apb_done && pwrite && (paddr == REG_TX_DATA);
   assign fifo_pop = apb_done && !pwrite && (paddr == REG_RX_DATA);
   assign target = (bit_idx == 4'h0) ? at_least_one(period >> 1) : period;

   always_comb begin
      status.debug_mode = debug_mode; // RULE13
      status.halted = cpu_halted; // RULE14
      status.read_protect_option_effect = !flash_read_lock_option; // RULE15
      status.reserved = STATUS_RESERVED; // RULE16
   end

   // Received characters queue here; with the queue full, one more waits in rx_hold and the receiver then stays idle
   ocdbg_fifo #(
      .WIDTH(CHAR_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(rx_hold_valid),
      .in_ready(fifo_in_ready),
      .in_data(rx_hold),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // Link, unlock and debug-mode state
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_period = period;
      next_bit_idx = bit_idx;
      next_shreg = shreg;
      next_key_len = key_len;
      next_key_shift = key_shift;
      next_key_cnt = key_cnt;
      next_unlocked = unlocked;
      next_debug_mode = debug_mode;
      next_rx_hold_valid = rx_hold_valid && !fifo_in_ready;
      next_rx_hold = rx_hold;
      next_tx_pend_valid = tx_pend_valid;
      next_tx_pend = tx_pend;
      next_sysrst = stop_wake; // RULE2

      if (tx_write && !tx_pend_valid) begin
         next_tx_pend_valid = 1'b1;
         next_tx_pend = pwdata[7:0];
      end
      if (ctrl_write && !pwdata[CTRL_DEBUG_POS]) begin
         next_debug_mode = 1'b0; // RULE1
      end

      if (hard_rst) begin
         next_unlocked = 1'b0;
      end

      if (hard_rst || pin_rst || stop_wake) begin
         // Every reset source drops debug mode and re-arms autobaud, or returns a locked small part to ST_LOCKED
         next_debug_mode = 1'b0; // RULE1
         next_state = (small_pin_part && !next_unlocked) ? ST_LOCKED : ST_BAUD_WAIT; // RULE7
         next_cnt = '0;
         next_bit_idx = '0;
         next_tx_pend_valid = 1'b0;
         if (pin_rst && !hard_rst && small_pin_part && !unlocked) begin
            // Key bits are low pulses; width decides the bit value
            if (!debug_line_in) begin
               next_key_len = (key_len == '1) ? key_len : CNT_W'(key_len + 1'b1);
            end else if (!line_q) begin
               next_key_shift = {key_shift[KEY_BITS-2:0], (key_len >= KEY_SPLIT_CYC)};
               next_key_len = '0;
               if (key_cnt == 6'(KEY_BITS - 1)) begin
                  next_key_cnt = '0;
                  next_unlocked = (next_key_shift == KEY_VALUE); // RULE11
               end else begin
                  next_key_cnt = 6'(key_cnt + 1'b1);
               end
            end
         end else begin
            next_key_len = '0;
            next_key_cnt = '0;
         end
      end else begin
         case (state)
            ST_LOCKED: begin
               if (!small_pin_part || unlocked) begin
                  next_state = ST_BAUD_WAIT; // RULE12
               end
            end
            ST_BAUD_WAIT: begin
               if (!debug_line_in) begin
                  next_state = ST_BAUD_MEASURE;
                  next_cnt = 16'h0001;
               end
            end
            ST_BAUD_MEASURE: begin
               if (debug_line_in) begin
                  // Eight low bit times measured; shift by three gives one bit
                  next_period = at_least_one(cnt >> AUTOBAUD_SHIFT); // RULE9 RULE10
                  next_debug_mode = 1'b1; // RULE12
                  next_state = ST_IDLE;
                  next_cnt = '0;
               end else if (cnt != '1) begin
                  next_cnt = CNT_W'(cnt + 1'b1);
               end
            end
            ST_IDLE: begin
               next_cnt = '0;
               next_bit_idx = '0;
               if (!rx_hold_valid && !debug_line_in && line_q) begin
                  next_state = ST_RX;
               end else if (tx_pend_valid) begin
                  next_state = ST_TX; // RULE4
                  next_shreg = {1'b1, tx_pend, 1'b0}; // RULE3
                  next_tx_pend_valid = 1'b0;
               end
            end
            ST_RX: begin
               next_cnt = CNT_W'(cnt + 1'b1);
               if (next_cnt >= target) begin
                  next_cnt = '0;
                  if (bit_idx == 4'h0 && debug_line_in) begin
                     next_state = ST_IDLE;
                  end else begin
                     next_shreg = {debug_line_in, shreg[FRAME_BITS-1:1]}; // RULE3
                     next_bit_idx = 4'(bit_idx + 1'b1);
                     if (bit_idx == 4'(FRAME_BITS - 1)) begin
                        // Stop sampled mid-bit; the line is free for a reply now
                        next_state = ST_IDLE; // RULE4
                        if (debug_line_in) begin
                           next_rx_hold_valid = 1'b1;
                           next_rx_hold = next_shreg[CHAR_BITS:1];
                        end
                     end
                  end
               end
            end
            ST_TX: begin
               next_cnt = CNT_W'(cnt + 1'b1);
               if (next_cnt >= period) begin
                  next_cnt = '0;
                  next_shreg = {1'b1, shreg[FRAME_BITS-1:1]};
                  next_bit_idx = 4'(bit_idx + 1'b1);
                  if (bit_idx == 4'(FRAME_BITS - 1)) begin
                     next_state = ST_IDLE;
                  end
               end
            end
            default: begin
               next_state = ST_BAUD_WAIT;
            end
         endcase
      end

      // The port drives only while a frame is being sent
      next_line_oe_n = (next_state != ST_TX); // RULE7
      next_line_out = (next_state == ST_TX) ? next_shreg[0] : 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_LOCKED;
         cnt <= '0;
         period <= MIN_PERIOD;
         bit_idx <= '0;
         shreg <= '1;
         key_len <= '0;
         key_shift <= '0;
         key_cnt <= '0;
         unlocked <= 1'b0;
         debug_mode <= 1'b0;
         line_q <= 1'b1;
         rx_hold_valid <= 1'b0;
         rx_hold <= '0;
         tx_pend_valid <= 1'b0;
         tx_pend <= '0;
         debug_line_out <= 1'b1;
         debug_line_oe_n <= 1'b1;
         system_reset_req <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         period <= next_period;
         bit_idx <= next_bit_idx;
         shreg <= next_shreg;
         key_len <= next_key_len;
         key_shift <= next_key_shift;
         key_cnt <= next_key_cnt;
         unlocked <= next_unlocked;
         debug_mode <= next_debug_mode;
         line_q <= debug_line_in;
         rx_hold_valid <= next_rx_hold_valid;
         rx_hold <= next_rx_hold;
         tx_pend_valid <= next_tx_pend_valid;
         tx_pend <= next_tx_pend;
         debug_line_out <= next_line_out;
         debug_line_oe_n <= next_line_oe_n;
         system_reset_req <= next_sysrst;
      end
   end

   // APB slave: read data is captured in the setup cycle, answer in the first access cycle
   always_comb begin
      next_pready = psel && !penable;
      next_pslverr = 1'b0;
      next_prdata = '0;
      if (psel && !penable) begin
         next_pslverr = !is_mapped(paddr) || (pwrite && (paddr == REG_STATE_REPORT || paddr == REG_RX_DATA ||
                        paddr == REG_BIT_PERIOD)) || (pwrite && paddr == REG_TX_DATA && tx_pend_valid);
         if (!pwrite) begin
            case (paddr)
               REG_STATE_REPORT: next_prdata = {24'h000000, status}; // RULE13 RULE14 RULE15 RULE16
               REG_CONTROL: next_prdata = {31'h00000000, debug_mode};
               REG_RX_DATA: next_prdata = {23'h000000, fifo_out_valid, fifo_out_data};
               REG_TX_DATA: next_prdata = {23'h000000, tx_pend_valid, tx_pend};
               REG_BIT_PERIOD: next_prdata = {16'h0000, period};
               default: next_prdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

endmodule : ocdbg_port

// >>> common/ocdbg_pkg.sv
// Shared constants and types of the on-chip debugger serial port.
// Assumes a 250 MHz pclk and a 32-bit APB register bus.
package ocdbg_pkg;

   localparam int ADDR_W = 8;
   localparam int CNT_W = 16;
   localparam int CHAR_BITS = 8;
   localparam int FRAME_BITS = 10;
   localparam int FIFO_DEPTH = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_STATE_REPORT = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h04;
   localparam logic [ADDR_W-1:0] REG_RX_DATA = 8'h08;
   localparam logic [ADDR_W-1:0] REG_TX_DATA = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_BIT_PERIOD = 8'h10;

   // Field positions
   localparam int CTRL_DEBUG_POS = 0;
   localparam int DATA_FLAG_POS = 8;

   localparam logic [7:0] STATE_REPORT_RESET = 8'h00;
   localparam logic [4:0] STATUS_RESERVED = 5'h00;

   // Autobaud: the 80h character is eight low bit times, so the period is count / 8
   localparam int AUTOBAUD_SHIFT = 3;
   localparam logic [CNT_W-1:0] MIN_PERIOD = 16'h0001;

   // Unlock key: 32 low pulses, long pulse is a one; the value is arbitrary
   localparam int KEY_BITS = 32;
   localparam logic [31:0] KEY_VALUE = 32'h5a3c_96e1;
   localparam int CLK_PERIOD_NS = 4;
   localparam int KEY_SPLIT_NS = 1000;
   localparam logic [CNT_W-1:0] KEY_SPLIT_CYC = CNT_W'((KEY_SPLIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      ST_LOCKED = 3'b000,
      ST_BAUD_WAIT = 3'b001,
      ST_BAUD_MEASURE = 3'b010,
      ST_IDLE = 3'b011,
      ST_RX = 3'b100,
      ST_TX = 3'b101
   } ocdbg_state_t;

   typedef struct packed {
      logic debug_mode;
      logic halted;
      logic read_protect_option_effect;
      logic [4:0] reserved;
   } ocdbg_status_t;

endpackage : ocdbg_pkg

// >>> logic/ocdbg_fifo.sv
// Synchronous FIFO with valid/ready on both sides, flip-flop storage.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module ocdbg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [PW:0] count, next_count;
   logic push, pop;

   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         next_count = (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (PW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage needs no reset; out_valid guards it
   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule : ocdbg_fifo

// >>> tb/ocdbg_assertions.sv
// Concurrent checks of the debug port, bound to its top module.
// Assumes one pclk domain and an active-low presetn.
`timescale 1ns/1ps
module ocdbg_assertions
   import ocdbg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic debug_line_in,
   input wire logic debug_line_out,
   input wire logic debug_line_oe_n,
   input wire logic shared_reset_pin_in,
   input wire logic small_pin_part,
   input wire logic power_on_reset,
   input wire logic brown_out_reset,
   input wire logic watchdog_reset,
   input wire logic stop_mode,
   input wire logic cpu_halted,
   input wire logic flash_read_lock_option,
   input wire logic system_reset_req,
   input wire logic debug_mode
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Set once the host has pulled the line; any reset source rearms it
   // A reset or stop wake may cut a frame short, so no stop bit follows it
   logic heard, next_heard, any_rst, cut;
   always_comb begin
      any_rst = power_on_reset || brown_out_reset || watchdog_reset || !shared_reset_pin_in;
      cut = any_rst || (stop_mode && !debug_line_in);
      next_heard = (heard || !debug_line_in) && !any_rst;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         heard <= 1'b0;
      end else begin
         heard <= next_heard;
      end
   end
   sequence stat_rd;
      psel && penable && pready && !pwrite && paddr == REG_STATE_REPORT;
   endsequence
   sequence tx_start;
      $fell(debug_line_oe_n) && !debug_line_out;
   endsequence
   sequence tx_hold;
      !debug_line_oe_n [*8];
   endsequence
   AST_STAT_RSV: assert property (stat_rd |-> prdata[4:0] == STATUS_RESERVED && prdata[31:8] == 24'h0)
      else $error("reserved status bits not zero");
   AST_STAT_HALT: assert property (stat_rd |-> prdata[6] == $past(cpu_halted))
      else $error("halt status bit wrong");
   AST_STAT_LOCK: assert property (stat_rd |-> prdata[5] == !$past(flash_read_lock_option))
      else $error("read lock status bit wrong");
   AST_STAT_RO: assert property (psel && penable && pready && pwrite && paddr == REG_STATE_REPORT |-> pslverr)
      else $error("write to status register accepted");
   AST_IDLE: assert property (!heard |-> debug_line_oe_n)
      else $error("line driven before host spoke");
   AST_STOP_WAKE: assert property (stop_mode && !debug_line_in |=> system_reset_req)
      else $error("no reset request from stop");
   AST_RST_SRC: assert property (any_rst |=> !debug_mode)
      else $error("debug mode kept over reset");
   AST_CLR: assert property (psel && penable && pready && pwrite && paddr == REG_CONTROL
      && !pwdata[CTRL_DEBUG_POS] && debug_mode |=> !debug_mode)
      else $error("debug mode kept after clear");
   AST_TX_START: assert property ($fell(debug_line_oe_n) |-> tx_start ##1 tx_hold)
      else $error("bad start of sent frame");
   AST_TX_STOP: assert property ($rose(debug_line_oe_n) && !$past(cut) |-> $past(debug_line_out))
      else $error("sent frame ends without high stop bit");
endmodule : ocdbg_assertions
bind ocdbg_port ocdbg_assertions u_ocdbg_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .debug_line_in, .debug_line_out, .debug_line_oe_n, .shared_reset_pin_in, .small_pin_part,
   .power_on_reset, .brown_out_reset, .watchdog_reset, .stop_mode, .cpu_halted,
   .flash_read_lock_option, .system_reset_req, .debug_mode
);

// >>> tb/ocdbg_host.sv
// Behavioural debug host on the single-wire link.
// Assumes a pull-up on the line and a bit period of P pclk cycles.
`timescale 1ns/1ps
module ocdbg_host
   import ocdbg_pkg::*;
#(
   parameter int P = 8
) (
   input wire logic pclk,
   input wire logic line,
   output logic drive_low
);
   // Open-drain: only ever pulls low, so a stop bit is never driven high
   initial begin
      drive_low = 1'b0;
   end
   // The gap lets the host answer promptly or slowly
   task automatic send(input logic [7:0] b, input int gap);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      repeat (gap) @(posedge pclk);
      for (int i = 0; i < FRAME_BITS; i++) begin
         @(posedge pclk);
         drive_low <= !f[i];
         repeat (P - 1) @(posedge pclk);
      end
   endtask : send
   task automatic pull(input int n);
      @(posedge pclk);
      drive_low <= 1'b1;
      repeat (n) @(posedge pclk);
      drive_low <= 1'b0;
   endtask : pull
   // Mid-bit sampling; r[8] holds the stop bit
   task automatic recv(output logic [8:0] r);
      int n;
      n = 0;
      while (line !== 1'b0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      repeat (P / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         repeat (P) @(posedge pclk);
         r[i] = line;
      end
   endtask : recv
endmodule : ocdbg_host

// >>> tb/ocdbg_port_bench.sv
// Self-checking bench of the debug port with a host model on the line.
// Assumes one-cycle APB answers are possible but waits on pready.
`timescale 1ns/1ps
module ocdbg_port_bench
   import ocdbg_pkg::*;
;
   localparam logic [32:0] ALL = 33'h1_ffff_ffff;
   localparam logic [32:0] ERR = 33'h1_0000_0000;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] src = 4'h0;
   logic [1:0] hl = 2'h0;
   logic stop_mode = 1'b0;
   logic small_part = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, debug_line_out, debug_line_oe_n, system_reset_req, debug_mode, host_low, dline;
   int seed = 82;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [65:0] expq[$];
   logic [65:0] note;
   logic [7:0] bq[$];
   logic [7:0] b;
   logic [8:0] r;
   always #2 pclk = ~pclk;
   // Pull-up wire: low whenever either party pulls it
   assign dline = !((!debug_line_oe_n && !debug_line_out) || host_low);
   ocdbg_port DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .debug_line_in(dline), .debug_line_out(debug_line_out), .debug_line_oe_n(debug_line_oe_n),
      .shared_reset_pin_in(!src[3]), .small_pin_part(small_part), .power_on_reset(src[0]),
      .brown_out_reset(src[1]), .watchdog_reset(src[2]), .stop_mode(stop_mode), .cpu_halted(hl[1]),
      .flash_read_lock_option(hl[0]), .system_reset_req(system_reset_req), .debug_mode(debug_mode)
   );
   ocdbg_host #(.P(8)) host (.pclk(pclk), .line(dline), .drive_low(host_low));
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   // Notes the expected answer, then runs one setup and access phase
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                      input logic [32:0] m);
      expq.push_back({e & m, m});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic stat(input logic dbg);
      apb(1'b0, REG_STATE_REPORT, 32'h0, {25'h0, dbg, hl[1], !hl[0], STATUS_RESERVED}, ALL);
   endtask : stat
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
         note = expq.pop_front();
         check({pslverr, prdata} & note[32:0], note[65:33]);
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 10000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      hl <= 2'($random(seed));
      @(posedge pclk);
      stat(1'b0);
      apb(1'b0, REG_BIT_PERIOD, 32'h0, 33'h1, ALL);
      apb(1'b1, REG_STATE_REPORT, 32'($random(seed)), ERR, ERR);
      apb(1'b0, 8'h14, 32'h0, ERR, ERR);
      host.send(8'h80, 0);
      repeat (2) @(posedge pclk);
      stat(1'b1);
      apb(1'b0, REG_BIT_PERIOD, 32'h0, 33'h8, ALL);
      // One byte more than the buffer holds: the last waits for room
      for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
         b = 8'($random(seed));
         bq.push_back(b);
         host.send(b, i % 3);
      end
      for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
         apb(1'b0, REG_RX_DATA, 32'h0, {24'h0, 1'b1, bq.pop_front()}, ALL);
      end
      apb(1'b0, REG_RX_DATA, 32'h0, 33'h0, 33'h1_0000_0100);
      b = 8'($random(seed));
      apb(1'b1, REG_TX_DATA, {24'h0, b}, 33'h0, ERR);
      host.recv(r);
      check({24'h0, r}, {25'h1, b});
      apb(1'b1, REG_CONTROL, 32'h0, 33'h0, ERR);
      apb(1'b0, REG_CONTROL, 32'h0, 33'h0, ALL);
      stop_mode <= 1'b1;
      host.pull(3);
      check({32'h0, system_reset_req}, 33'h1);
      stop_mode <= 1'b0;
      // A fresh rate character enters debug mode, then each reset source in turn ends it
      for (int i = 0; i < 4; i++) begin
         host.send(8'h80, 2);
         repeat (2) @(posedge pclk);
         check({32'h0, debug_mode}, 33'h1);
         src <= 4'h1 << i;
         @(posedge pclk);
         src <= 4'h0;
         @(posedge pclk);
         check({32'h0, debug_mode}, 33'h0);
      end
      // Small part: the rate character is ignored until the key arrives with the reset pin low
      @(posedge pclk);
      small_part <= 1'b1;
      src <= 4'h8;
      @(posedge pclk);
      src <= 4'h0;
      host.send(8'h80, 2);
      repeat (2) @(posedge pclk);
      check({32'h0, debug_mode}, 33'h0);
      src <= 4'h8;
      for (int k = KEY_BITS - 1; k >= 0; k--) begin
         host.pull(KEY_VALUE[k] ? 260 : 20);
      end
      @(posedge pclk);
      src <= 4'h0;
      host.send(8'h80, 2);
      repeat (2) @(posedge pclk);
      check({32'h0, debug_mode}, 33'h1);
      give_verdict();
   end
endmodule : ocdbg_port_bench
